/* File: hdl/pbs_bus_phase.sv */
// bus phasing engine: initiator and target of a multiplexed 32-bit bus
// assumes one clock, pins resolved outside from the output enables
//
// Functional notes
// - one address phase, then data phases
// - initiator drives address and write data only
// - target samples address, drives read data
// - all updates and samples on rising edge
// - command code on cbe in address phase
// - byte enables held through each data phase
// - enable bit n governs byte lane n
// - cbe driven as initiator, sampled as target
// - even parity over ad and cbe
// - parity lags its ad phase by one clock
// - parity driven only with own ad phases
// - received parity checked, mismatch flagged open-drain
// - frame held until the final data phase
// - frame driven as initiator, sampled as target
// - bus clock at most 33 MHz
// - 128-word outgoing buffer absorbs bus latency
// - parity error four clocks after ad
`timescale 1ns/1ps
`include "pbs_cfg.svh"

module pbs_bus_phase
#(
  parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH,
  parameter int BUS_CLK_HZ = `PBS_FMAX_HZ
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pbs_pkg::pbs_pin_in_t pin_i,
  output pbs_pkg::pbs_pin_out_t pin_o,
  input wire logic mreq_valid,
  output logic mreq_ready,
  input wire pbs_pkg::pbs_mreq_t mreq,
  input wire logic wbuf_valid,
  output logic wbuf_ready,
  input wire pbs_pkg::pbs_word_t wbuf_word,
  output logic mrd_valid,
  output pbs_pkg::pbs_word_t mrd_word,
  input wire logic [`PBS_AD_W-1:0] tgt_base,
  output logic tgt_wr_valid,
  output pbs_pkg::pbs_word_t tgt_wr_word,
  output logic tgt_rd_strobe,
  input wire logic [`PBS_AD_W-1:0] tgt_rd_data,
  output logic perr_event
);
  import pbs_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int FW = $clog2(FIFO_DEPTH + 1);

  // ********************************
  // elaboration checks
  // ********************************
  if (BUS_CLK_HZ > `PBS_FMAX_HZ || BUS_CLK_HZ <= 0)
  begin : g_bad_clk
    $error("bus clock above the supported maximum");
  end
  if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH)
  begin : g_bad_depth
    $error("buffer depth must be a power of two, at least 2");
  end

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    pbs_mst_t mst;
    pbs_tgt_t tgt;
    logic write;
    logic [`PBS_LEN_W-1:0] cnt;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [FW-1:0] fcnt;
    pbs_pin_out_t o;
    pbs_smp_t smp_m;
    pbs_smp_t smp_s;
    logic frame_p;
    logic drv1;
    logic drv2;
    logic pdrv1;
    logic pdrv2;
    logic skip1;
    logic skip2;
    logic tskip;
    logic chk_q;
    logic chk_par;
    logic mrd1;
    logic mrd2;
    logic mrd_valid;
    pbs_word_t mrd_word;
    logic [`PBS_CBE_W-1:0] tbe;
    logic twr_valid;
    pbs_word_t twr_word;
  } pbs_state_t;

  pbs_state_t q;
  pbs_state_t s;
  pbs_word_t mem [FIFO_DEPTH];
  logic push;
  logic pop;
  logic chk;
  logic err;

  // ********************************
  // helpers
  // ********************************
  function automatic logic even_par(input logic [`PBS_AD_W-1:0] ad,
                                    input logic [`PBS_CBE_W-1:0] cbe);
    even_par = ^{ad, cbe};
  endfunction

  function automatic logic [`PBS_LEN_W-1:0] eff_len(
    input logic [`PBS_LEN_W-1:0] len);
    eff_len = (len == '0) ? `PBS_LEN_ONE : len;
  endfunction

  function automatic logic hit(input logic [`PBS_AD_W-1:0] ad,
                               input logic [`PBS_AD_W-1:0] base);
    hit = ad[`PBS_AD_W-1:`PBS_DEC_LSB] == base[`PBS_AD_W-1:`PBS_DEC_LSB];
  endfunction

  // ********************************
  // handshakes
  // ********************************
  assign wbuf_ready = int'(q.fcnt) < FIFO_DEPTH;
  assign push = wbuf_valid && wbuf_ready;
  assign mreq_ready = (q.mst == PBS_M_IDLE) && (q.tgt == PBS_T_IDLE)
    && !q.smp_s.frame && !q.frame_p && !q.o.frame_oe
    && (!mreq.write || int'(q.fcnt) >= int'(eff_len(mreq.len)));

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    s = q;
    pop = 1'b0;
    tgt_rd_strobe = 1'b0;

    // two-stage capture of every bus input
    s.smp_m = '{ad: pin_i.ad, cbe: pin_i.cbe, par: pin_i.par,
                frame: !pin_i.frame_n};
    s.smp_s = q.smp_m;
    s.frame_p = q.smp_s.frame;
    s.drv1 = q.o.ad_oe;
    s.drv2 = q.drv1;
    s.pdrv1 = q.o.par_oe;
    s.pdrv2 = q.pdrv1;
    s.skip1 = q.mst == PBS_M_TA;
    s.skip2 = q.skip1;
    s.tskip = 1'b0;
    s.mrd1 = (q.mst == PBS_M_DATA) && !q.write;
    s.mrd2 = q.mrd1;
    s.twr_valid = 1'b0;

    // parity trails whatever we drove one cycle earlier
    s.o.par = even_par(q.o.ad, q.o.cbe_oe ? q.o.cbe : q.tbe);
    s.o.par_oe = q.o.ad_oe;

    // initiator sequencing
    case (q.mst)
      PBS_M_IDLE:
      begin
        if (mreq_valid && mreq_ready)
        begin
          s.mst = PBS_M_ADDR;
          s.write = mreq.write;
          s.cnt = eff_len(mreq.len);
          s.o.ad = mreq.addr;
          s.o.ad_oe = 1'b1;
          s.o.cbe = mreq.cmd;
          s.o.cbe_oe = 1'b1;
          s.o.frame_n = 1'b0;
          s.o.frame_oe = 1'b1;
        end
      end
      PBS_M_ADDR, PBS_M_TA, PBS_M_DATA:
      begin
        if (q.mst == PBS_M_ADDR && !q.write)
        begin
          // release ad one cycle before the target drives it
          s.mst = PBS_M_TA;
          s.o.ad_oe = 1'b0;
          s.o.cbe = `PBS_BE_ALL;
        end
        else if (q.mst == PBS_M_DATA && q.o.frame_n)
        begin
          s.mst = PBS_M_TURN;
          s.o.ad_oe = 1'b0;
          s.o.cbe_oe = 1'b0;
          s.o.frame_oe = 1'b0;
        end
        else
        begin
          s.mst = PBS_M_DATA;
          s.cnt = q.cnt - `PBS_LEN_ONE;
          s.o.frame_n = q.cnt == `PBS_LEN_ONE;
          if (q.write)
          begin
            pop = 1'b1;
            s.o.ad = mem[q.rptr].data;
            s.o.cbe = mem[q.rptr].be;
            s.o.ad_oe = 1'b1;
          end
          else
          begin
            s.o.ad_oe = 1'b0;
            s.o.cbe = `PBS_BE_ALL;
          end
        end
      end
      PBS_M_TURN:
      begin
        s.mst = PBS_M_IDLE;
      end
      default:
      begin
        s.mst = PBS_M_IDLE;
        s.o.ad_oe = 1'b0;
        s.o.cbe_oe = 1'b0;
        s.o.frame_oe = 1'b0;
      end
    endcase

    // initiator read data, aligned with the input capture
    s.mrd_valid = q.mrd2;
    if (q.mrd2)
    begin
      s.mrd_word = '{be: q.smp_s.cbe, data: q.smp_s.ad};
    end

    // target sequencing on captured bus values
    case (q.tgt)
      PBS_T_IDLE:
      begin
        if (q.mst == PBS_M_IDLE && !q.drv2 && q.smp_s.frame
            && !q.frame_p && hit(q.smp_s.ad, tgt_base))
        begin
          if (q.smp_s.cbe == `PBS_CMD_MEM_RD)
          begin
            s.tgt = PBS_T_TURN;
            s.tskip = 1'b1;
          end
          else if (q.smp_s.cbe == `PBS_CMD_MEM_WR)
          begin
            s.tgt = PBS_T_WR;
          end
        end
      end
      PBS_T_WR:
      begin
        s.twr_valid = 1'b1;
        s.twr_word = '{be: q.smp_s.cbe, data: q.smp_s.ad};
        if (!q.smp_s.frame)
        begin
          s.tgt = PBS_T_IDLE;
        end
      end
      PBS_T_TURN:
      begin
        // one idle cycle before taking over ad
        s.tgt = PBS_T_RD;
        s.o.ad = tgt_rd_data;
        s.o.ad_oe = 1'b1;
        s.tbe = q.smp_s.cbe;
        tgt_rd_strobe = 1'b1;
      end
      PBS_T_RD:
      begin
        s.tbe = q.smp_s.cbe;
        if (!q.smp_s.frame)
        begin
          s.tgt = PBS_T_REL;
          s.o.ad_oe = 1'b0;
        end
        else
        begin
          s.o.ad = tgt_rd_data;
          tgt_rd_strobe = 1'b1;
        end
      end
      PBS_T_REL:
      begin
        s.tgt = PBS_T_IDLE;
      end
      default:
      begin
        s.tgt = PBS_T_IDLE;
        s.o.ad_oe = 1'b0;
      end
    endcase

    // parity check: ad stage now, parity stage next cycle
    // target read wait phases carry nobody's parity
    chk = (q.smp_s.frame || q.frame_p) && !q.drv2 && !q.skip2
      && !q.tskip && (q.tgt != PBS_T_TURN) && (q.tgt != PBS_T_RD);
    s.chk_q = chk;
    s.chk_par = even_par(q.smp_s.ad, q.smp_s.cbe);
    err = q.chk_q && !q.pdrv2 && (q.smp_s.par != q.chk_par);
    s.o.perr_oe = err;
    s.o.perr_n = !err;

    // buffer pointers
    if (push)
    begin
      s.wptr = q.wptr + PW'(1);
    end
    if (pop)
    begin
      s.rptr = q.rptr + PW'(1);
    end
    s.fcnt = q.fcnt + FW'(push) - FW'(pop);
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en && push)
    begin
      mem[q.wptr] <= wbuf_word;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign pin_o = q.o;
  assign mrd_valid = q.mrd_valid;
  assign mrd_word = q.mrd_word;
  assign tgt_wr_valid = q.twr_valid;
  assign tgt_wr_word = q.twr_word;
  assign perr_event = q.o.perr_oe;

endmodule

/* File: hdl/pbs_cfg.svh */
// constants of the bus phasing block
// assumes inclusion by the package, the design module, the checker and the bench
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_AD_W 32
`define PBS_CBE_W 4
`define PBS_LEN_W 8
`define PBS_FIFO_DEPTH 128
`define PBS_FMAX_HZ 33000000
`define PBS_DEC_LSB 8
`define PBS_CMD_MEM_RD 4'h6
`define PBS_CMD_MEM_WR 4'h7
`define PBS_BE_ALL 4'hF
`define PBS_LEN_ONE 8'h01

`endif

/* File: hdl/pbs_pkg.sv */
// types of the bus phasing block
// assumes pbs_cfg.svh on the include path
`include "pbs_cfg.svh"

package pbs_pkg;

  typedef enum logic [2:0]
  {
    PBS_M_IDLE = 3'b000,
    PBS_M_ADDR = 3'b001,
    PBS_M_TA = 3'b010,
    PBS_M_DATA = 3'b011,
    PBS_M_TURN = 3'b100
  } pbs_mst_t;

  typedef enum logic [2:0]
  {
    PBS_T_IDLE = 3'b000,
    PBS_T_TURN = 3'b001,
    PBS_T_RD = 3'b010,
    PBS_T_WR = 3'b011,
    PBS_T_REL = 3'b100
  } pbs_tgt_t;

  typedef struct packed {
    logic [`PBS_AD_W-1:0] ad;
    logic [`PBS_CBE_W-1:0] cbe;
    logic par;
    logic frame_n;
  } pbs_pin_in_t;

  typedef struct packed {
    logic [`PBS_AD_W-1:0] ad;
    logic ad_oe;
    logic [`PBS_CBE_W-1:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic frame_oe;
    logic perr_n;
    logic perr_oe;
  } pbs_pin_out_t;

  typedef struct packed {
    logic [`PBS_AD_W-1:0] ad;
    logic [`PBS_CBE_W-1:0] cbe;
    logic par;
    logic frame;
  } pbs_smp_t;

  typedef struct packed {
    logic [`PBS_CBE_W-1:0] be;
    logic [`PBS_AD_W-1:0] data;
  } pbs_word_t;

  typedef struct packed {
    logic [`PBS_AD_W-1:0] addr;
    logic [`PBS_CBE_W-1:0] cmd;
    logic write;
    logic [`PBS_LEN_W-1:0] len;
  } pbs_mreq_t;

endpackage

/* File: testbench/pbs_bus_phase_checker.sv */
// pin timing checks of the bus phasing block
// assumes binding to pbs_bus_phase, one clock
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module pbs_bus_phase_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pbs_pkg::pbs_pin_in_t pin_i,
  input wire pbs_pkg::pbs_pin_out_t pin_o,
  input wire logic mrd_valid,
  input wire pbs_pkg::pbs_word_t mrd_word,
  input wire logic tgt_wr_valid,
  input wire pbs_pkg::pbs_word_t tgt_wr_word,
  input wire logic tgt_rd_strobe,
  input wire logic [`PBS_AD_W-1:0] tgt_rd_data,
  input wire logic perr_event
);
  import pbs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****
  // assertions
  // ****
  addr_phase_a: assert property (
    $rose(pin_o.frame_oe) |-> pin_o.ad_oe && !pin_o.frame_n
    ##1 pin_o.par_oe) else $error("address phase malformed");
  par_lag_a: assert property (
    $past(pin_o.ad_oe) && $past(pin_o.cbe_oe) |-> pin_o.par_oe
    && pin_o.par == ^{$past(pin_o.ad), $past(pin_o.cbe)})
    else $error("parity wrong");
  par_own_a: assert property (
    pin_o.par_oe |-> $past(pin_o.ad_oe)) else $error("stray parity");
  frame_run_a: assert property (
    pin_o.frame_oe && !pin_o.frame_n |=> pin_o.frame_oe)
    else $error("frame dropped early");
  frame_end_a: assert property (
    pin_o.frame_oe && pin_o.frame_n |=> !pin_o.frame_oe)
    else $error("frame not released");
  cbe_drive_a: assert property (
    pin_o.frame_oe |-> pin_o.cbe_oe) else $error("cbe not driven");
  tgt_cbe_a: assert property (
    pin_o.ad_oe && !pin_o.frame_oe |-> !pin_o.cbe_oe)
    else $error("target drove cbe");
  perr_pulse_a: assert property (
    pin_o.perr_oe |-> !pin_o.perr_n && perr_event ##1 !pin_o.perr_oe)
    else $error("parity error pulse bad");
  read_word_a: assert property (
    mrd_valid |-> $past(pin_o.frame_oe, 3) && !$past(pin_o.ad_oe, 3)
    && mrd_word.data == $past(pin_i.ad, 3)) else $error("read word bad");
  tgt_word_a: assert property (
    tgt_wr_valid |-> tgt_wr_word == {$past(pin_i.cbe, 3),
    $past(pin_i.ad, 3)}) else $error("target word bad");
  tgt_read_a: assert property (
    tgt_rd_strobe |=> pin_o.ad_oe && pin_o.ad == $past(tgt_rd_data))
    else $error("target read data bad");
  cover property (mrd_valid);
  cover property (tgt_wr_valid);
  cover property (perr_event);
  cover property (tgt_rd_strobe);
endmodule

/* File: testbench/pbs_far_agent.sv */
// far bus agent: answers reads, runs transfers as far initiator
// assumes pins resolved here from both sides' enables
`timescale 1ns/1ps
module pbs_far_agent
(
  input wire logic clk,
  input wire pbs_pkg::pbs_pin_out_t pin_o,
  output pbs_pkg::pbs_pin_in_t pin_i
);
  import pbs_pkg::*;
  logic [31:0] ad = 0, ad_q = 0, rd_data = 0;
  logic [3:0] cbe = 0;
  logic ad_oe = 0, cbe_oe = 0, fr_n = 1, fr_oe = 0;
  logic par_q = 0, par_oe = 0, bad_par = 0;
  logic [1:0] rd_st = 0;
  logic fr_q = 0;
  // ****
  // wires; released ad toggles, frame pulled up
  // ****
  assign pin_i.ad = pin_o.ad_oe ? pin_o.ad : ad_oe ? ad : ~ad_q;
  assign pin_i.cbe = pin_o.cbe_oe ? pin_o.cbe : cbe_oe ? cbe : ~ad_q[3:0];
  assign pin_i.par = pin_o.par_oe ? pin_o.par : par_oe ? par_q : ad_q[0];
  assign pin_i.frame_n = pin_o.frame_oe ? pin_o.frame_n : !fr_oe | fr_n;
  always @(posedge clk)
  begin
    ad_q <= pin_i.ad;
    par_q <= ^{pin_i.ad, pin_i.cbe, bad_par};
    par_oe <= ad_oe;
    fr_q <= pin_o.frame_oe;
    // only an address phase may start a read answer
    if (pin_o.frame_oe && !fr_q && pin_o.ad_oe && pin_o.cbe == 4'h6)
      rd_st <= 1;
    else if (rd_st == 1)
    begin
      rd_st <= 2;
      ad_oe <= 1;
      ad <= rd_data;
    end
    else if (rd_st == 2)
    begin
      ad <= ad + 1;
      if (pin_o.frame_n)
      begin
        ad_oe <= 0;
        rd_st <= 0;
      end
    end
  end
  task automatic mst(input logic [31:0] a, input logic [3:0] c,
    input pbs_word_t w, input int n, input int bi);
    @(posedge clk);
    fr_oe <= 1;
    fr_n <= 0;
    ad_oe <= 1;
    cbe_oe <= 1;
    ad <= a;
    cbe <= c;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      ad_oe <= c == 4'h7;
      ad <= w.data + i;
      cbe <= w.be;
      fr_n <= i == n - 1;
      bad_par <= i == bi;
    end
    @(posedge clk);
    fr_oe <= 0;
    ad_oe <= 0;
    cbe_oe <= 0;
    bad_par <= 0;
  endtask
endmodule

/* File: testbench/pbs_bus_phase_tb.sv */
// self-checking bench of the bus phasing block
// assumes the far agent and the checker files
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module pbs_bus_phase_tb;
  import pbs_pkg::*;
  logic clk = 0, rst_n = 0, clk_en = 0, mreq_valid = 0, wbuf_valid = 0;
  logic mreq_ready, wbuf_ready, mrd_valid, tgt_wr_valid, tgt_rd_strobe;
  logic perr_event;
  pbs_mreq_t mreq = '0;
  pbs_word_t wbuf_word = '0;
  pbs_word_t mrd_word, tgt_wr_word, w;
  pbs_pin_in_t pin_i;
  pbs_pin_out_t pin_o;
  logic [31:0] tgt_base = 0, tgt_rd_data = 0;
  pbs_word_t exp[$];
  int seed = 32'h5F10;
  int failures = 0, cmp_count = 0, perr_cnt = 0, drv_cnt = 0;
  pbs_bus_phase dut_u (.clk, .rst_n, .clk_en, .pin_i, .pin_o,
    .mreq_valid, .mreq_ready, .mreq, .wbuf_valid, .wbuf_ready, .wbuf_word,
    .mrd_valid, .mrd_word, .tgt_base, .tgt_wr_valid, .tgt_wr_word,
    .tgt_rd_strobe, .tgt_rd_data, .perr_event);
  pbs_far_agent far_u (.clk, .pin_o, .pin_i);
  initial
    forever #12.5 clk = ~clk;
  // ****
  // checking
  // ****
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input pbs_word_t s, input pbs_word_t e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic take(input pbs_word_t s);
    check(s, exp.size() > 0 ? exp.pop_front() : 36'hX);
  endtask
  always @(posedge clk)
  begin
    if (pin_o.frame_oe && pin_o.ad_oe)
      take({pin_o.cbe, pin_o.ad});
    if (mrd_valid)
      take(mrd_word);
    if (tgt_wr_valid)
      take(tgt_wr_word);
    if (pin_o.ad_oe && !pin_o.frame_oe)
    begin
      drv_cnt++;
      check({4'h0, pin_o.ad}, {4'h0, tgt_rd_data});
    end
    if (perr_event)
      perr_cnt++;
  end
  task automatic settle;
    for (int k = 0; k < 40 && exp.size() > 0; k++)
      @(posedge clk);
    if (exp.size() > 0)
    begin
      failures++;
      close_out();
    end
    repeat (6) @(posedge clk);
  endtask
  // ****
  // stimulus
  // ****
  task automatic mst_run(input logic wr);
    logic [31:0] a;
    logic [3:0] c;
    int k;
    a = $random(seed);
    c = wr ? `PBS_CMD_MEM_WR : `PBS_CMD_MEM_RD;
    mreq <= '{a, c, wr, 8'h02};
    exp.push_back({c, a});
    w = {4'($random(seed)), 32'($random(seed))};
    far_u.rd_data = w.data;
    wbuf_valid <= wr;
    for (k = 0; k < 2; k++)
    begin
      wbuf_word <= w;
      exp.push_back({wr ? w.be : 4'hF, w.data});
      @(posedge clk);
      w.data++;
    end
    wbuf_valid <= 0;
    mreq_valid <= 1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (mreq_ready !== 1 && k < 50);
    mreq_valid <= 0;
    if (k >= 50)
    begin
      failures++;
      close_out();
    end
    settle();
    $display("master case %0d done", wr);
  endtask
  task automatic far_run(input int t);
    w = {4'($random(seed)), 32'($random(seed))};
    if (t < 2)
    begin
      exp.push_back(w);
      exp.push_back({w.be, w.data + 32'h1});
    end
    far_u.mst(t < 2 ? tgt_base | 32'h4 : tgt_base ^ 32'h100,
      `PBS_CMD_MEM_WR, w, 2, t == 1 ? 0 : -1);
    settle();
    $display("target case %0d done", t);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    clk_en <= 1;
    tgt_base <= $random(seed) & 32'hFFFFFF00;
    tgt_rd_data <= $random(seed);
    mst_run(1'b1);
    mst_run(1'b0);
    for (int t = 0; t < 3; t++)
      far_run(t);
    far_u.mst(tgt_base, `PBS_CMD_MEM_RD, {4'hF, 32'h0}, 5, -1);
    settle();
    $display("target read done");
    // frozen block must not take a standing request
    clk_en <= 0;
    mreq_valid <= 1;
    repeat (4)
    begin
      @(posedge clk);
      check(36'(pin_o.frame_oe), 36'h0);
    end
    mreq_valid <= 0;
    clk_en <= 1;
    settle();
    $display("clock enable case done");
    check(36'(drv_cnt > 0), 36'h1);
    check(36'(perr_cnt), 36'h1);
    close_out();
  end
endmodule
bind pbs_bus_phase pbs_bus_phase_checker chk_u (.clk, .rst_n, .pin_i,
  .pin_o, .mrd_valid, .mrd_word, .tgt_wr_valid, .tgt_wr_word,
  .tgt_rd_strobe, .tgt_rd_data, .perr_event);
